// ==== pcm_voice_codec_port.sv ====
/*
  Serial voice codec port: bit clock, frame sync, data in and data out
  towards an external PCM or I2S codec, two channels, master or slave.
  Assumes a 125 MHz reference clock, a simple one-cycle register port
  driven from the same clock, and codec pins joined by the bench.
*/
// Notes on behaviour
// - Master drives clock and sync; slave receives
// - Clock, sync directional; data out drivable or high-Z
// - Slave works with bit clock up to 16 MHz
// - Above 12 MHz slave bursts limited to 32 bits
// - Master bit clock selectable 64 kHz to 6 MHz
// - Length 8 to 320 bits, 640 single channel
// - Each channel holds its own length
// - Per channel start position from frame sync
// - Bit order chosen per direction and channel
// - LSB first only up to 24 bit samples
// - Receive and transmit lengths set independently
// - Data out released outside channel slots
// - Option keeps data out permanently high-Z
// - Data out high-Z after power-up
// - Mu-law, A-law, linear, transparent coding per channel
// - Long or short frame sync selectable
// - Shift edge and sampling polarity selectable
// - Master holds clock low in idle window
`timescale 1ns/1ns
`include "pcm_port_map.svh"
module pcm_voice_codec_port
  import pcm_port_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Register port
  input wire logic [5:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Bit clock pin
  input wire logic PCM_CLK,
  output logic PCM_CLK_DRV,
  output logic PCM_CLK_EN,
  // Frame sync pin
  input wire logic PCM_FS,
  output logic PCM_FS_DRV,
  output logic PCM_FS_EN,
  // Data lines
  input wire logic PCM_DIN,
  output logic PCM_DOUT,
  output logic PCM_DOUT_EN
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Clamp a word length to the legal window of the current mode
  function automatic logic [9:0] len_eff(logic [9:0] l, logic dual,
                                         logic fast);
    logic [9:0] m;
    m = dual ? 10'(`LEN_MAX2) : 10'(`LEN_MAX1);
    if (fast) begin
      m = 10'(`LEN_FAST);
    end
    if (l < 10'(`LEN_MIN)) begin
      return 10'(`LEN_MIN);
    end
    return (l > m) ? m : l;
  endfunction

  // True while bit position p lies inside a slot
  function automatic logic slot_hit(logic [10:0] p, logic [9:0] pos,
                                    logic [9:0] len);
    return (p >= {1'b0, pos}) && (p < {1'b0, pos} + {1'b0, len});
  endfunction

  // Idle window of the master clock, empty when stop is not past start
  function automatic logic in_idle(logic [10:0] f, idle_reg_t w);
    return (w.stop > w.start) && (f >= w.start) && (f < w.stop);
  endfunction

  // Companded codes travel as 8-bit line codes; the inversion is its
  // own inverse, so the same function serves both directions
  function automatic logic [31:0] recode(logic [31:0] v, coding_t m);
    case (m)
      COD_MULAW: return v ^ 32'(`MU_XOR);
      COD_ALAW: return v ^ 32'(`A_XOR);
      default: return v;
    endcase
  endfunction

  // Reset image of the whole state
  function automatic state_t init_state();
    state_t s;
    s = '0;
    s.sh.div = `DIV_RST;
    s.sh.flen = `FLEN_RST;
    for (int c = 0; c < 2; c++) begin
      s.sh.rx[c].len = `LEN_RST;
      s.sh.tx[c].len = `LEN_RST;
      s.sh.rx[c].cod = COD_LINEAR;
      s.sh.tx[c].cod = COD_LINEAR;
      s.sh.rx[c].msb = 1'b1;
      s.sh.tx[c].msb = 1'b1;
    end
    s.sh.rx[1].pos = `POS1_RST;
    s.sh.tx[1].pos = `POS1_RST;
    s.act = s.sh;
    return s;
  endfunction

  localparam state_t ST_RST = init_state();

  // ****************************************************************
  // State and helper signals
  // ****************************************************************
  state_t r;
  state_t n;
  logic [9:0] divc;
  logic [9:0] len_rx [2];
  logic [9:0] len_tx [2];
  logic fstart;
  logic cur_hit;
  logic cur_idle;
  logic idle_n;
  logic slv_fast;
  ctrl_reg_t cw;
  stat_reg_t sw;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // One pass computes every next value; order matters where a
  // hardware set must win over a software clear in the same cycle
  always_comb begin
    logic rise, fall, vr, vf, drv, smp, fsin, din, msb;
    logic [10:0] p;
    logic [10:0] k;
    logic [31:0] w;
    rise = 1'b0;
    fall = 1'b0;
    vr = 1'b0;
    vf = 1'b0;
    drv = 1'b0;
    smp = 1'b0;
    fsin = 1'b0;
    din = 1'b0;
    msb = 1'b0;
    p = '0;
    k = '0;
    w = '0;
    n = r;
    fstart = 1'b0;
    cur_hit = 1'b0;
    cw = ctrl_reg_t'(WDATA & `CTRL_MASK);
    sw = '0;
    sw.frames = r.frames;
    sw.bitpos = r.bitcnt;
    sw.too_fast = r.too_fast;
    sw.fast = r.fast;
    sw.rx_vld = r.rx_vld;

    // Register writes land in the shadow copy, except transmit data, which goes straight to txd
    if (WR) begin
      case (ADDR)
        `A_CTRL: n.sh.ctrl = cw;
        `A_DIV: n.sh.div = WDATA[9:0];
        `A_FRAME: n.sh.flen = WDATA[10:0];
        `A_IDLE: n.sh.idle = idle_reg_t'(WDATA & `IDLE_MASK);
        `A_RX0: n.sh.rx[0] = slot_reg_t'(WDATA & `SLOT_MASK);
        `A_TX0: n.sh.tx[0] = slot_reg_t'(WDATA & `SLOT_MASK);
        `A_RX1: n.sh.rx[1] = slot_reg_t'(WDATA & `SLOT_MASK);
        `A_TX1: n.sh.tx[1] = slot_reg_t'(WDATA & `SLOT_MASK);
        `A_TXD0: n.txd[0] = WDATA;
        `A_TXD1: n.txd[1] = WDATA;
        default: ;
      endcase
    end

    // Reads answer one cycle later; data reads clear their flags
    n.rdata = '0;
    if (RD) begin
      case (ADDR)
        `A_CTRL: n.rdata = r.sh.ctrl;
        `A_DIV: n.rdata = 32'(r.sh.div);
        `A_FRAME: n.rdata = 32'(r.sh.flen);
        `A_IDLE: n.rdata = r.sh.idle;
        `A_RX0: n.rdata = r.sh.rx[0];
        `A_TX0: n.rdata = r.sh.tx[0];
        `A_RX1: n.rdata = r.sh.rx[1];
        `A_TX1: n.rdata = r.sh.tx[1];
        `A_TXD0: n.rdata = r.txd[0];
        `A_TXD1: n.rdata = r.txd[1];
        `A_RXD0: begin
          n.rdata = r.rxd[0];
          n.rx_vld[0] = 1'b0;
        end
        `A_RXD1: begin
          n.rdata = r.rxd[1];
          n.rx_vld[1] = 1'b0;
        end
        `A_STAT: begin
          n.rdata = sw;
          n.too_fast = 1'b0;
        end
        default: n.rdata = '0;
      endcase
    end

    // Effective settings of the active copy
    divc = r.act.div;
    if (divc < 10'(`DIV_MIN)) begin
      divc = 10'(`DIV_MIN);
    end
    if (divc > 10'(`DIV_MAX)) begin
      divc = 10'(`DIV_MAX);
    end
    slv_fast = r.fast & ~r.act.ctrl.master;
    for (int c = 0; c < 2; c++) begin
      len_rx[c] = len_eff(r.act.rx[c].len, r.act.ctrl.dual, slv_fast);
      len_tx[c] = len_eff(r.act.tx[c].len, r.act.ctrl.dual, slv_fast);
    end

    // Pin synchronisers; the second stage is read below, the clock's third stage for edges
    n.ck1 = PCM_CLK;
    n.ck2 = r.ck1;
    n.ck3 = r.ck2;
    n.fs1 = PCM_FS;
    n.fs2 = r.fs1;
    n.d1 = PCM_DIN;
    n.d2 = r.d1;

    // Slave clock period, to spot rates above 12 MHz or 16 MHz
    if (r.ck2 && !r.ck3) begin
      n.per = '0;
      n.fast = ({1'b0, r.per} + 6'd1) <= 6'(`FAST_CYC);
      if (({1'b0, r.per} + 6'd1) < 6'(`SLV_MIN_CYC) &&
          r.act.ctrl.en && !r.act.ctrl.master) begin
        n.too_fast = 1'b1;
      end
    end else if (r.per != '1) begin
      n.per = r.per + 5'd1;
    end

    // Master clock divider and frame timer
    if (r.act.ctrl.en && r.act.ctrl.master) begin
      if (r.dcnt == '0) begin
        n.dcnt = divc - 10'd1;
        n.ph = ~r.ph;
        vr = ~r.ph;
        vf = r.ph;
      end else begin
        n.dcnt = r.dcnt - 10'd1;
      end
    end else begin
      n.dcnt = '0;
      n.ph = 1'b0;
      n.fcnt = '0;
    end
    if (vr) begin
      n.fcnt = (r.fcnt >= r.act.flen - 11'd1) ? '0 : r.fcnt + 11'd1;
    end
    idle_n = in_idle(n.fcnt, r.act.idle);
    cur_idle = in_idle(r.fcnt, r.act.idle);
    // Frame timer keeps running while the clock is held low
    n.bclk_o = n.ph & ~idle_n;
    n.fs_o = r.act.ctrl.en & r.act.ctrl.master &
      (r.act.ctrl.long_fs ? (n.fcnt < (r.act.flen >> 1))
                          : (n.fcnt == '0));

    // Edges of the bit clock, own or received
    if (r.act.ctrl.master) begin
      rise = vr & ~idle_n;
      fall = vf & ~idle_n;
      fsin = r.fs_o;
    end else begin
      rise = r.act.ctrl.en & r.ck2 & ~r.ck3;
      fall = r.act.ctrl.en & ~r.ck2 & r.ck3;
      fsin = r.fs2 ^ r.act.ctrl.fs_inv;
    end
    drv = r.act.ctrl.fall ? fall : rise;
    smp = r.act.ctrl.fall ? rise : fall;
    din = r.d2 ^ r.act.ctrl.din_inv;

    // Sync edge marks a boundary: settings switch only here or while disabled
    if (smp) begin
      n.fs_prev = fsin;
      if (fsin && !r.fs_prev) begin
        n.start = 1'b1;
        n.act = r.sh;
        fstart = 1'b1;
      end
    end
    if (!r.act.ctrl.en) begin
      n.act = r.sh;
      n.in_frame = 1'b0;
      n.start = 1'b0;
      n.doe = 1'b0; // Stale enable must not reappear on re-enable
    end

    // Drive edge: next bit position and serial output
    if (drv) begin
      if (r.start) begin
        p = '0;
        n.start = 1'b0;
        n.in_frame = 1'b1;
        n.frames = r.frames + 16'd1;
      end else begin
        p = (r.bitcnt == '1) ? r.bitcnt : r.bitcnt + 11'd1;
      end
      n.bitcnt = p;
      n.dout = 1'b0;
      n.doe = 1'b0;
      for (int c = 0; c < 2; c++) begin
        if ((r.in_frame || r.start) && (c == 0 || r.act.ctrl.dual) &&
            slot_hit(p, r.act.tx[c].pos, len_tx[c])) begin
          k = p - {1'b0, r.act.tx[c].pos};
          msb = r.act.tx[c].msb ||
            (len_tx[c] > 10'(`LSB_MAX));
          if (k == '0) begin
            w = recode(r.txd[c], r.act.tx[c].cod);
            if (msb && len_tx[c] < 10'(`WORD_W)) begin
              w = w << (10'(`WORD_W) - len_tx[c]);
            end
          end else begin
            w = r.tx_sr[c];
          end
          // Overlapping slots: channel 0 owns the line
          if (!n.doe) begin
            n.dout = msb ? w[31] : w[0];
            n.doe = 1'b1;
          end
          n.tx_sr[c] = msb ? (w << 1) : (w >> 1);
        end
      end
    end

    // Sample edge: gather received bits per channel
    if (smp && r.in_frame) begin
      for (int c = 0; c < 2; c++) begin
        if ((c == 0 || r.act.ctrl.dual) &&
            slot_hit(r.bitcnt, r.act.rx[c].pos, len_rx[c])) begin
          k = r.bitcnt - {1'b0, r.act.rx[c].pos};
          msb = r.act.rx[c].msb ||
            (len_rx[c] > 10'(`LSB_MAX));
          w = (k == '0) ? '0 : r.rx_sr[c];
          w = msb ? {w[30:0], din} : {din, w[31:1]};
          n.rx_sr[c] = w;
          if (k == {1'b0, len_rx[c]} - 11'd1) begin
            if (!msb && len_rx[c] < 10'(`WORD_W)) begin
              w = w >> (10'(`WORD_W) - len_rx[c]);
            end
            n.rxd[c] = recode(w, r.act.rx[c].cod);
            n.rx_vld[c] = 1'b1;
          end
        end
      end
    end

    // Slot test at the current position, for the output check
    for (int c = 0; c < 2; c++) begin
      if (r.in_frame && (c == 0 || r.act.ctrl.dual) &&
          slot_hit(r.bitcnt, r.act.tx[c].pos, len_tx[c])) begin
        cur_hit = 1'b1;
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // All state in one record; reset restores the documented defaults
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      r <= ST_RST;
    end else begin
      r <= n;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Enables gate late so a stale bit never escapes after a change
  assign RDATA = r.rdata;
  assign PCM_CLK_DRV = r.bclk_o;
  assign PCM_CLK_EN = r.act.ctrl.en & r.act.ctrl.master;
  assign PCM_FS_DRV = r.fs_o ^ r.act.ctrl.fs_inv;
  assign PCM_FS_EN = r.act.ctrl.en & r.act.ctrl.master;
  assign PCM_DOUT = r.dout;
  assign PCM_DOUT_EN = r.doe & r.act.ctrl.en & r.act.ctrl.dout_en &
    ~r.act.ctrl.hiz;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  AST_HIZ_PERM: assert property (
    r.act.ctrl.hiz |-> !PCM_DOUT_EN)
    else $error("data out driven while forced high-Z");

  AST_DOUT_SLOT: assert property (
    (PCM_DOUT_EN && !r.start) |-> cur_hit)
    else $error("data out driven outside a slot");

  AST_DOUT_PWRUP: assert property (
    (!r.sh.ctrl.dout_en && !r.act.ctrl.dout_en) |-> !PCM_DOUT_EN)
    else $error("data out driven before enabled");

  AST_SLAVE_PINS: assert property (
    !r.act.ctrl.master |-> (!PCM_CLK_EN && !PCM_FS_EN))
    else $error("slave drives clock or sync");

  AST_MASTER_PINS: assert property (
    (r.act.ctrl.en && r.act.ctrl.master) [*2] |->
      (PCM_CLK_EN && PCM_FS_EN))
    else $error("master fails to drive clock and sync");

  AST_DIV_RANGE: assert property (
    r.act.ctrl.master |->
      (divc >= 10'(`DIV_MIN) && divc <= 10'(`DIV_MAX)))
    else $error("master divider out of range");

  AST_LEN_RANGE: assert property (
    (len_rx[0] >= 10'(`LEN_MIN)) && (len_tx[1] >= 10'(`LEN_MIN)) &&
    (len_tx[0] <= (r.act.ctrl.dual ? 10'(`LEN_MAX2) : 10'(`LEN_MAX1))))
    else $error("word length outside limits");

  AST_LEN_FAST: assert property (
    slv_fast |-> (len_rx[0] <= 10'(`LEN_FAST) &&
                  len_tx[1] <= 10'(`LEN_FAST)))
    else $error("long burst at fast slave clock");

  AST_CFG_FRAME: assert property (
    (r.act != $past(r.act)) |-> ($past(fstart) || !$past(r.act.ctrl.en)))
    else $error("settings changed inside a frame");

  AST_FS_FRAME: assert property (
    (r.act.ctrl.en && r.act.ctrl.master && $changed(r.fcnt) &&
     r.fcnt == '0) |-> r.fs_o)
    else $error("no sync at frame start");

  AST_IDLE_LOW: assert property (
    (r.act.ctrl.master && cur_idle) |-> !r.bclk_o)
    else $error("clock toggles in idle window");

endmodule

// ==== pcm_port_map.svh ====
/*
  Constants of the serial voice codec port: rates, derived cycle counts,
  length limits, register offsets, write masks and reset values.
  Assumes a reference clock of 125 MHz; included by the package and core.
*/
`ifndef PCM_PORT_MAP_SVH
`define PCM_PORT_MAP_SVH

// ******************************************************************
// Rates and derived cycle counts
// ******************************************************************
`define CLK_HZ 125_000_000
`define SLV_MAX_HZ 16_000_000
`define FAST_HZ 12_000_000
`define MST_MAX_HZ 6_000_000
`define MST_MIN_HZ 64_000
// Least half period rounds up, longest half period rounds down
`define DIV_MIN ((`CLK_HZ + 2 * `MST_MAX_HZ - 1) / (2 * `MST_MAX_HZ))
`define DIV_MAX (`CLK_HZ / (2 * `MST_MIN_HZ))
`define FAST_CYC (`CLK_HZ / `FAST_HZ)
`define SLV_MIN_CYC (`CLK_HZ / `SLV_MAX_HZ)

// ******************************************************************
// Word lengths
// ******************************************************************
`define LEN_MIN 8
`define LEN_MAX2 320
`define LEN_MAX1 640
`define LEN_FAST 32
`define LSB_MAX 24
`define WORD_W 32

// ******************************************************************
// Register offsets (byte addresses)
// ******************************************************************
`define A_CTRL 6'h00
`define A_DIV 6'h04
`define A_FRAME 6'h08
`define A_IDLE 6'h0C
`define A_RX0 6'h10
`define A_TX0 6'h14
`define A_RX1 6'h18
`define A_TX1 6'h1C
`define A_TXD0 6'h20
`define A_TXD1 6'h24
`define A_RXD0 6'h28
`define A_RXD1 6'h2C
`define A_STAT 6'h30

// ******************************************************************
// Write masks, reset values, line codes
// ******************************************************************
`define CTRL_MASK 32'h0000_01FF
`define SLOT_MASK 32'hD3FF_03FF
`define IDLE_MASK 32'h07FF_07FF
`define DIV_RST 10'h03E
`define FLEN_RST 11'h064
`define LEN_RST 10'h010
`define POS1_RST 10'h010
`define MU_XOR 8'hFF
`define A_XOR 8'h55

`endif

// ==== pcm_port_pkg.sv ====
/*
  Types of the serial voice codec port: register layouts, the
  configuration carrier and the core's state record.
  Assumes the constants header is on the include path.
*/
package pcm_port_pkg;
  `include "pcm_port_map.svh"

  // ****************************************************************
  // Register layouts
  // ****************************************************************
  typedef enum logic [1:0] {COD_MULAW, COD_ALAW, COD_LINEAR,
    COD_TRANSP} coding_t;

  typedef struct packed {
    logic [22:0] rsv;
    logic dout_en;
    logic hiz;
    logic din_inv;
    logic fs_inv;
    logic fall;
    logic long_fs;
    logic dual;
    logic master;
    logic en;
  } ctrl_reg_t;

  typedef struct packed {
    coding_t cod;
    logic rsv1;
    logic msb;
    logic [1:0] rsv2;
    logic [9:0] len;
    logic [5:0] rsv3;
    logic [9:0] pos;
  } slot_reg_t;

  typedef struct packed {
    logic [4:0] rsv1;
    logic [10:0] stop;
    logic [4:0] rsv0;
    logic [10:0] start;
  } idle_reg_t;

  typedef struct packed {
    logic [15:0] frames;
    logic [10:0] bitpos;
    logic rsv;
    logic too_fast;
    logic fast;
    logic [1:0] rx_vld;
  } stat_reg_t;

  // ****************************************************************
  // Configuration carrier and core state
  // ****************************************************************
  typedef struct packed {
    ctrl_reg_t ctrl;
    logic [9:0] div;
    logic [10:0] flen;
    idle_reg_t idle;
    slot_reg_t [1:0] rx;
    slot_reg_t [1:0] tx;
  } cfg_t;

  typedef struct packed {
    cfg_t sh;
    cfg_t act;
    logic ck1, ck2, ck3, fs1, fs2, d1, d2;
    logic [9:0] dcnt;
    logic ph;
    logic [10:0] fcnt;
    logic bclk_o, fs_o, fs_prev, start, in_frame;
    logic [10:0] bitcnt;
    logic [1:0][31:0] txd;
    logic [1:0][31:0] rxd;
    logic [1:0][31:0] tx_sr;
    logic [1:0][31:0] rx_sr;
    logic [1:0] rx_vld;
    logic [4:0] per;
    logic fast, too_fast;
    logic dout, doe;
    logic [15:0] frames;
    logic [31:0] rdata;
  } state_t;
endpackage

// ==== pcm_codec_model.sv ====
/*
  Behavioural codec at the far side of the voice port: makes the bit
  clock and frame sync, drives data in, captures data out per frame.
  Assumes the bench resolves the pins and reads the captured frame.
*/
`timescale 1ns/1ns
module pcm_codec_model (
  // Bench control
  input wire logic run,
  input wire logic [63:0] din_frame,
  input wire logic [63:0] din_mask,
  // Codec pins
  output logic bclk,
  output logic fs,
  output logic din,
  input wire logic dout,
  input wire logic dout_en,
  // Last whole frame seen on data out
  output logic [63:0] got,
  output logic [63:0] got_en,
  output logic [15:0] frames
);
  logic [5:0] pos;
  logic [63:0] cap;
  logic [63:0] cap_en;
  // Clock stands still while idle; 80 ns stays under the slave ceiling
  initial begin
    {bclk, fs, din, pos, frames} = {3'b000, 6'h3E, 16'h0000};
    {got, got_en, cap, cap_en} = 256'h0;
    #13;
    forever begin
      if (run) begin
        #40 bclk = 1'b1;
        pos = pos + 6'h01;
        fs = (pos == 6'h3F);
        // Outside its slots the line flips, so no stale bit passes
        din = din_mask[63 - pos] ? din_frame[63 - pos] : ~din;
        #40 bclk = 1'b0;
        cap[63 - pos] = dout;
        cap_en[63 - pos] = dout_en;
        if (pos == 6'h3F) begin
          {got, got_en} = {cap, cap_en};
          frames = frames + 16'h0001;
        end
      end else begin
        #8;
      end
    end
  end
endmodule

// ==== testbench.sv ====
/*
  Self-checking bench of the voice codec port: registers, master clock
  and sync, slave traffic against the codec model.
  Assumes the design files and the codec model are compiled first.
*/
`timescale 1ns/1ns
`include "pcm_port_map.svh"
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin \
  fails++; $display("FAIL %s expected %h seen %h", nm, e, s); end end
module testbench;
  import pcm_port_pkg::*;
  logic REF_CLK, RST, WR, RD, run, c_clk, c_fs, c_din;
  logic [5:0] ADDR;
  logic [31:0] WDATA, RDATA, v;
  logic PCM_CLK_DRV, PCM_CLK_EN, PCM_FS_DRV, PCM_FS_EN;
  logic PCM_DOUT, PCM_DOUT_EN;
  logic [63:0] din_frame, din_mask, got, got_en, ee, ed;
  logic [15:0] frames;
  int fails, checks_done;
  wire pin_clk;
  wire pin_fs;
  logic [5:0] ra [7] = '{`A_CTRL, `A_DIV, `A_FRAME, `A_IDLE, `A_RX0,
    `A_TX1, 6'h34};
  logic [31:0] rv [7] = '{32'h0, 32'h0000_003E, 32'h0000_0064, 32'h0,
    32'h9010_0000, 32'h9010_0010, 32'h0};
  logic [31:0] ctab [4] = '{32'h0000_0101, 32'h0000_0105, 32'h0000_0185,
    32'h0000_0045};
  // Pin level follows whichever side enables its driver
  assign pin_clk = PCM_CLK_EN ? PCM_CLK_DRV : c_clk;
  assign pin_fs = PCM_FS_EN ? PCM_FS_DRV : c_fs;
  pcm_voice_codec_port DUT (.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PCM_CLK(pin_clk),
    .PCM_CLK_DRV(PCM_CLK_DRV), .PCM_CLK_EN(PCM_CLK_EN), .PCM_FS(pin_fs),
    .PCM_FS_DRV(PCM_FS_DRV), .PCM_FS_EN(PCM_FS_EN), .PCM_DIN(c_din),
    .PCM_DOUT(PCM_DOUT), .PCM_DOUT_EN(PCM_DOUT_EN));
  pcm_codec_model codec (.run(run), .din_frame(din_frame),
    .din_mask(din_mask), .bclk(c_clk), .fs(c_fs), .din(c_din),
    .dout(PCM_DOUT), .dout_en(PCM_DOUT_EN), .got(got), .got_en(got_en),
    .frames(frames));
  // 125 MHz reference
  initial begin
    REF_CLK = 1'b0;
    forever #4 REF_CLK = ~REF_CLK;
  end
  // ******************************************************************
  // Bus cycles, expectations, verdict
  // ******************************************************************
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge REF_CLK);
    WR <= 1'b0;
    @(posedge REF_CLK);
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge REF_CLK);
    RD <= 1'b0;
    #1 d = RDATA;
    @(posedge REF_CLK);
  endtask
  function automatic logic [63:0] bits(int p, int l, logic m,
      logic [31:0] w);
    logic [63:0] r;
    r = '0;
    for (int i = 0; i < l; i++) r[63 - p - i] = m ? w[l - 1 - i] : w[i];
    return r;
  endfunction
  function automatic logic [31:0] recode(coding_t c, logic [31:0] w);
    return w ^ {24'h00_0000, c == COD_MULAW ? `MU_XOR :
      c == COD_ALAW ? `A_XOR : 8'h00};
  endfunction
  function automatic slot_reg_t slot(int p, int l, logic m, coding_t c);
    slot_reg_t s;
    s = '0;
    {s.pos, s.len, s.msb, s.cod} = {p[9:0], l[9:0], m, c};
    return s;
  endfunction
  task automatic close_out;
    $display("Mismatches %0d in %0d checks", fails, checks_done);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ******************************************************************
  // Master: half period, rises per frame, sync width
  // ******************************************************************
  task automatic m_case(int dv, int fl, int lg, int is, int ie);
    int st, n, rs, fh, hi, mn, mx;
    logic pc, pf;
    {st, n, rs, fh, hi, mn, mx} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd0,
      32'd9999, 32'd0};
    wr(`A_CTRL, 32'h0);
    wr(`A_DIV, 32'(dv));
    wr(`A_FRAME, 32'(fl));
    wr(`A_IDLE, {5'h0, 11'(ie), 5'h0, 11'(is)});
    wr(`A_CTRL, 32'h0000_0103 | 32'(lg << 3));
    pc = PCM_CLK_DRV;
    pf = PCM_FS_DRV;
    // First frame may still carry one half period of the old divider
    while (st < 3 && n < 50000) begin
      @(posedge REF_CLK);
      #1 n++;
      if (PCM_FS_DRV === 1'b1 && pf === 1'b0) st++;
      if (st == 2 && PCM_CLK_DRV === 1'b1 && pc === 1'b0) begin
        rs++;
        fh += PCM_FS_DRV;
      end
      if (st == 2 && PCM_CLK_DRV === 1'b0 && pc === 1'b1) begin
        mn = hi < mn ? hi : mn;
        mx = hi > mx ? hi : mx;
      end
      hi = PCM_CLK_DRV === 1'b1 ? hi + 1 : 0;
      pc = PCM_CLK_DRV;
      pf = PCM_FS_DRV;
    end
    `CHK("clk_en", 1'b1, PCM_CLK_EN)
    `CHK("fs_en", 1'b1, PCM_FS_EN)
    `CHK("half_min", dv, mn)
    `CHK("half_max", dv, mx)
    `CHK("rises", fl - (ie > is ? ie - is : 0), rs)
    `CHK("fs_high", lg ? fl / 2 : 1, fh)
    `CHK("syncs", 3, st)
  endtask
  // ******************************************************************
  // Slave: random slots against the codec model
  // ******************************************************************
  task automatic s_case(int it);
    int l0, p0, l1, lr, e0, n;
    logic m0, m1, mr;
    coding_t c0, c1;
    logic [31:0] w0, w1, wx, ctl, mk;
    logic [15:0] f;
    ctl = ctab[it % 4];
    c0 = coding_t'(it % 4);
    c1 = coding_t'($urandom % 4);
    {m0, m1, mr} = 3'($urandom);
    m0 = it == 0 ? 1'b0 : m0;
    l0 = it == 0 ? 40 : it == 1 ? 8 : 8 + $urandom % 33;
    e0 = l0 > 32 ? 32 : l0;
    p0 = $urandom % (33 - e0);
    l1 = 8 + $urandom % 25;
    lr = 8 + $urandom % 25;
    {w0, w1, wx} = {$urandom, $urandom, $urandom};
    mk = 32'((64'h1 << lr) - 64'h1);
    wr(`A_CTRL, 32'h0);
    wr(`A_TX0, slot(p0, l0, m0, c0));
    wr(`A_TX1, slot(32, l1, m1, c1));
    wr(`A_RX0, slot(p0, lr, mr, COD_LINEAR));
    wr(`A_TXD0, w0);
    wr(`A_TXD1, w1);
    din_frame <= bits(p0, lr, mr | (lr > 24), wx);
    din_mask <= bits(p0, lr, 1'b1, 32'hFFFF_FFFF);
    wr(`A_CTRL, ctl);
    f = frames;
    n = 0;
    while (16'(frames - f) < 16'h0003 && n < 5000) begin
      @(posedge REF_CLK);
      n++;
    end
    `CHK("s_frames", 16'h0003, 16'(frames - f))
    ee = ctl[7] || !ctl[8] ? 64'h0 : bits(p0, e0, 1'b1, 32'hFFFF_FFFF)
      | (ctl[2] ? bits(32, l1, 1'b1, 32'hFFFF_FFFF) : 64'h0);
    ed = bits(p0, e0, m0 | (e0 > 24), recode(c0, w0))
      | bits(32, l1, m1 | (l1 > 24), recode(c1, w1));
    `CHK("dout_en", ee, got_en)
    `CHK("dout", ed & ee, got & ee)
    rd(`A_RXD0, v);
    `CHK("rxd0", (ctl[6] ? ~wx : wx) & mk, v & mk)
    rd(`A_STAT, v);
    `CHK("fast", 2'b01, v[3:2])
  endtask
  // Hang guard, well beyond the expected run
  initial begin
    #900_000;
    fails++;
    close_out();
  end
  // Main sequence
  initial begin
    int n;
    {RST, WR, RD, run, ADDR, WDATA} = {4'b1000, 6'h00, 32'h0};
    {din_frame, din_mask} = 128'h0;
    {fails, checks_done} = 64'h0;
    v = $urandom(32'h9b74);
    repeat (10) @(posedge REF_CLK);
    `CHK("rdata", 32'h0, RDATA)
    `CHK("dout_en", 1'b0, PCM_DOUT_EN)
    `CHK("clk_en", 1'b0, PCM_CLK_EN)
    RST <= 1'b0;
    @(posedge REF_CLK);
    foreach (ra[i]) begin
      rd(ra[i], v);
      `CHK("reg", rv[i], v)
    end
    wr(6'h34, 32'hFFFF_FFFF);
    wr(`A_IDLE, 32'hFFFF_FFFF);
    rd(`A_IDLE, v);
    `CHK("idle", `IDLE_MASK, v)
    rd(6'h34, v);
    `CHK("unmapped", 32'h0, v)
    m_case(11, 16, 0, 0, 0);
    m_case(976, 4, 1, 0, 0);
    for (int i = 0; i < 3; i++) begin
      n = 20 + $urandom % 21;
      m_case(12 + $urandom % 40, n, $urandom % 2, n / 2 + 1, n / 2 + 4);
    end
    wr(`A_CTRL, 32'h0);
    // Master lets go of the clock only at its next frame boundary
    while (PCM_CLK_EN !== 1'b0) @(posedge REF_CLK);
    run <= 1'b1;
    for (int it = 0; it < 8; it++) s_case(it);
    close_out();
  end
endmodule
